// ---- rtl/cmcr_pkg.sv ----
// Package for the codec mixer control register bank
package cmcr_pkg;

   // ------------------------------------------------------------
   // Register indices (7-bit register address)
   // ------------------------------------------------------------
   localparam logic [6:0] RESET_IDX = 7'h00;
   localparam logic [6:0] MASTER_IDX = 7'h02;
   localparam logic [6:0] HP_IDX = 7'h04;
   localparam logic [6:0] MONO_IDX = 7'h06;
   localparam logic [6:0] BEEP_IDX = 7'h0A;
   localparam logic [6:0] PHONE_IDX = 7'h0C;
   localparam logic [6:0] PAGE_IDX = 7'h24;
   localparam logic [6:0] SERIAL_IDX = 7'h74;
   localparam logic [6:0] CLASS_IDX = 7'h60;
   localparam logic [6:0] SVID_IDX = 7'h62;
   localparam logic [6:0] SID_IDX = 7'h64;
   localparam logic [6:0] FUNC_IDX = 7'h68;
   localparam logic [6:0] SENSE_IDX = 7'h6A;
   localparam logic [3:0] PAGE_ONE = 4'h1;

   // ------------------------------------------------------------
   // Reset values and writable-bit masks
   // ------------------------------------------------------------
   localparam logic [15:0] MASTER_RST = 16'h8080;
   localparam logic [15:0] HP_RST = 16'h8080;
   localparam logic [15:0] MONO_RST = 16'h8000;
   localparam logic [15:0] BEEP_RST = 16'h8000;
   localparam logic [15:0] PHONE_RST = 16'h8008;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [15:0] STEREO_MASK = 16'h9F9F;
   localparam logic [15:0] MONO_MASK = 16'h801F;
   localparam logic [15:0] BEEP_MASK = 16'hDFFE;
   localparam logic [15:0] PAGE_MASK = 16'h000F;
   localparam logic [15:0] SERIAL_MASK = 16'hF03C;
   localparam logic [15:0] SENSE_MASK = 16'hE000;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int LMUTE_BIT = 15;
   localparam int RMUTE_BIT = 7;
   localparam int LLVL_LSB = 8;
   localparam int RLVL_LSB = 0;
   localparam int BEEP_SRC_BIT = 14;
   localparam int BEEP_DIV_LSB = 5;
   localparam int BEEP_GAIN_LSB = 1;
   localparam int CAP_HP_BIT = 4;
   localparam int CAP_DAC20_BIT = 7;
   localparam int CAP_ADC20_BIT = 9;
   localparam int ENH_CODE_LSB = 10;
   localparam int SLOT_MODE_BIT = 15;
   localparam int REGMAP_LSB = 12;
   localparam int DOVR_BIT = 5;
   localparam int DALIGN_BIT = 4;
   localparam int DZERO_BIT = 3;
   localparam int DLINK_BIT = 2;

   localparam logic [4:0] STEREO_ENH_CODE = 5'h00;
   localparam logic [9:0] CAPABILITY = 10'((1 << CAP_HP_BIT) | (1 << CAP_DAC20_BIT)
                                           | (1 << CAP_ADC20_BIT));

   // ------------------------------------------------------------
   // Beep timing
   // ------------------------------------------------------------
   localparam int CORE_CLK_HZ = 50_000_000;
   localparam int BEEP_BASE_HZ = 48_000;
   localparam int BEEP_TICK_CYC = CORE_CLK_HZ / BEEP_BASE_HZ;
   localparam logic [10:0] BEEP_TICK_LAST = 11'(BEEP_TICK_CYC - 1);

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic left_mute;
      logic [4:0] left_level;
      logic right_mute;
      logic [4:0] right_level;
   } cmcr_stereo_s;

   typedef struct packed {
      logic mute;
      logic [4:0] level;
   } cmcr_mono_s;

   typedef struct packed {
      logic mute;
      logic beep_source_select;
      logic [7:0] divisor;
      logic [3:0] gain;
   } cmcr_beep_s;

   typedef struct packed {
      logic sum_to_mono;
      logic [1:0] left_boost;
      logic [1:0] right_boost;
   } cmcr_mic_s;

   typedef struct packed {
      logic sixteen_bit_slot_mode;
      logic [2:0] register_map_select;
      logic digital_out_override;
      logic digital_out_alignment;
      logic digital_out_zero_fill;
      logic digital_out_link_mode;
   } cmcr_serial_s;

   function automatic cmcr_stereo_s cmcr_stereo(input logic [15:0] r);
      cmcr_stereo_s s;
      s.left_mute = r[LMUTE_BIT];
      s.left_level = r[LLVL_LSB +: 5];
      s.right_mute = r[RMUTE_BIT];
      s.right_level = r[RLVL_LSB +: 5];
      return s;
   endfunction : cmcr_stereo

   function automatic cmcr_mono_s cmcr_mono(input logic [15:0] r);
      cmcr_mono_s s;
      s.mute = r[LMUTE_BIT];
      s.level = r[RLVL_LSB +: 5];
      return s;
   endfunction : cmcr_mono

endpackage : cmcr_pkg

// ---- rtl/cmcr_top.sv ----
// Mixer control register bank with beep generator
// Behaviour
// - Write to reset register restores defaults
// - Serial config fields survive register reset
// - Page-one identity and sense bits: power-on only
// - Reset register reads capability and enhancement code
// - Master drives the line level output
// - Stereo layout: mutes 15/7, levels 12:8/4:0
// - Headphone and mono ignore master register
// - Headphone register, stereo layout, muted default
// - Mono: mute bit 15, level 4:0
// - Beep gain 4 bits at 4:1
// - Tone 48 kHz over four times divisor
// - Source bit 14 selects analog input
// - Reset pin low routes beep to outputs
// - Beep register field layout
// - Phone gain 5 bits, default 0 dB muted
// - Microphones summed to mono, boost only
module cmcr_top
   import cmcr_pkg::*;
(
   // Clock and power-on reset
   input wire logic I_CORE_CLK,
   input wire logic I_RST_N,
   // External hardware reset pin
   input wire logic I_EXT_RESET_N,
   // Register access from the link deframer
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [6:0] I_REG_ADDR,
   input wire logic [15:0] I_REG_WDATA,
   output logic [15:0] O_REG_RDATA,
   output logic O_REG_RVALID,
   // Microphone boost straps
   input wire logic [1:0] I_MIC_L_BOOST,
   input wire logic [1:0] I_MIC_R_BOOST,
   // Analog control outputs and serial configuration
   output cmcr_stereo_s O_LINE_LVL,
   output cmcr_stereo_s O_HP_LVL,
   output cmcr_mono_s O_MONO_LVL,
   output cmcr_mono_s O_PHONE_LVL,
   output cmcr_beep_s O_BEEP_CTRL,
   output logic O_BEEP_TONE,
   output logic O_BEEP_BYPASS,
   output cmcr_mic_s O_MIC_CTRL,
   output cmcr_serial_s O_SERIAL_CFG
);

   // ------------------------------------------------------------
   // Hardware reset pin synchroniser
   // ------------------------------------------------------------
   logic hw_meta_q;
   logic hw_sync_q;
   logic hw_rst;

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         hw_meta_q <= 1'b0;
         hw_sync_q <= 1'b0;
      end else begin
         hw_meta_q <= I_EXT_RESET_N;
         hw_sync_q <= hw_meta_q;
      end
   end

   assign hw_rst = !hw_sync_q;

   // ------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------
   logic wr_ok;
   logic soft_rst;
   logic page_one;
   logic [3:0] page_q;

   // Writes are dropped while the pin holds the device in reset
   assign wr_ok = I_REG_WR && !hw_rst;
   assign soft_rst = wr_ok && (I_REG_ADDR == RESET_IDX);
   assign page_one = (page_q == PAGE_ONE);

   function automatic logic hit(input logic [6:0] idx);
      return wr_ok && (I_REG_ADDR == idx);
   endfunction : hit

   // ------------------------------------------------------------
   // Mixer registers: cleared by pin, power-on or register reset
   // ------------------------------------------------------------
   logic [15:0] master_q;
   logic [15:0] hp_q;
   logic [15:0] mono_q;
   logic [15:0] beep_q;
   logic [15:0] phone_q;

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         master_q <= MASTER_RST;
         hp_q <= HP_RST;
         mono_q <= MONO_RST;
         beep_q <= BEEP_RST;
         phone_q <= PHONE_RST;
         page_q <= 4'h0;
      end else if (hw_rst || soft_rst) begin
         master_q <= MASTER_RST;
         hp_q <= HP_RST;
         mono_q <= MONO_RST;
         beep_q <= BEEP_RST;
         phone_q <= PHONE_RST;
         page_q <= 4'h0;
      end else begin
         // Reserved bits are masked off on the way in
         if (hit(MASTER_IDX)) master_q <= I_REG_WDATA & STEREO_MASK;
         if (hit(HP_IDX)) hp_q <= I_REG_WDATA & STEREO_MASK;
         if (hit(MONO_IDX)) mono_q <= I_REG_WDATA & MONO_MASK;
         if (hit(BEEP_IDX)) beep_q <= I_REG_WDATA & BEEP_MASK;
         if (hit(PHONE_IDX)) phone_q <= I_REG_WDATA & MONO_MASK;
         if (hit(PAGE_IDX)) page_q <= I_REG_WDATA[3:0];
      end
   end

   // ------------------------------------------------------------
   // Serial configuration: only pin or power-on reset clears it
   // ------------------------------------------------------------
   logic [15:0] serial_q;

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         serial_q <= ZERO16;
      end else if (hw_rst) begin
         serial_q <= ZERO16;
      end else if (hit(SERIAL_IDX)) begin
         serial_q <= I_REG_WDATA & SERIAL_MASK;
      end
   end

   // ------------------------------------------------------------
   // Page-one sticky registers: power-on reset only
   // ------------------------------------------------------------
   logic [15:0] class_q;
   logic [15:0] svid_q;
   logic [15:0] sid_q;
   logic [15:0] func_q;
   logic [15:0] sense_q;

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         class_q <= ZERO16;
         svid_q <= ZERO16;
         sid_q <= ZERO16;
         func_q <= ZERO16;
         sense_q <= ZERO16;
      end else if (page_one) begin
         // No reset branch here: survives pin and register resets
         if (hit(CLASS_IDX)) class_q <= I_REG_WDATA;
         if (hit(SVID_IDX)) svid_q <= I_REG_WDATA;
         if (hit(SID_IDX)) sid_q <= I_REG_WDATA;
         if (hit(FUNC_IDX)) func_q <= I_REG_WDATA;
         if (hit(SENSE_IDX)) sense_q <= I_REG_WDATA & SENSE_MASK;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [15:0] rd_d;
   logic [15:0] id_word;

   assign id_word = {1'b0, STEREO_ENH_CODE, CAPABILITY};

   always_comb begin
      rd_d = ZERO16;
      case (I_REG_ADDR)
         RESET_IDX: rd_d = id_word;
         MASTER_IDX: rd_d = master_q;
         HP_IDX: rd_d = hp_q;
         MONO_IDX: rd_d = mono_q;
         BEEP_IDX: rd_d = beep_q;
         PHONE_IDX: rd_d = phone_q;
         PAGE_IDX: rd_d = {12'h000, page_q};
         SERIAL_IDX: rd_d = serial_q;
         CLASS_IDX: rd_d = page_one ? class_q : ZERO16;
         SVID_IDX: rd_d = page_one ? svid_q : ZERO16;
         SID_IDX: rd_d = page_one ? sid_q : ZERO16;
         FUNC_IDX: rd_d = page_one ? func_q : ZERO16;
         SENSE_IDX: rd_d = page_one ? sense_q : ZERO16;
         default: rd_d = ZERO16;
      endcase
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_REG_RDATA <= ZERO16;
         O_REG_RVALID <= 1'b0;
      end else begin
         O_REG_RVALID <= I_REG_RD;
         if (I_REG_RD) O_REG_RDATA <= rd_d;
      end
   end

   // ------------------------------------------------------------
   // Digital beep generator
   // ------------------------------------------------------------
   logic [10:0] tick_q;
   logic tick_en;
   logic [8:0] half_q;
   logic tone_q;
   logic gen_run;
   logic [8:0] half_last;

   assign tick_en = (tick_q == BEEP_TICK_LAST);
   // Generation stops on zero divisor, mute or analog source
   assign gen_run = (beep_q[BEEP_DIV_LSB +: 8] != 8'h00) && !beep_q[LMUTE_BIT]
                    && !beep_q[BEEP_SRC_BIT];
   // Toggle every 2*div base ticks: period 4*div ticks
   assign half_last = 9'({beep_q[BEEP_DIV_LSB +: 8], 1'b0} - 9'h001);

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tick_q <= 11'h000;
      end else if (tick_en) begin
         tick_q <= 11'h000;
      end else begin
         tick_q <= tick_q + 11'h001;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         half_q <= 9'h000;
         tone_q <= 1'b0;
      end else if (!gen_run) begin
         half_q <= 9'h000;
         tone_q <= 1'b0;
      end else if (tick_en) begin
         if (half_q >= half_last) begin
            half_q <= 9'h000;
            tone_q <= !tone_q;
         end else begin
            half_q <= half_q + 9'h001;
         end
      end
   end

   // ------------------------------------------------------------
   // Registered control outputs
   // ------------------------------------------------------------
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_LINE_LVL <= cmcr_stereo(MASTER_RST);
         O_HP_LVL <= cmcr_stereo(HP_RST);
         O_MONO_LVL <= cmcr_mono(MONO_RST);
         O_PHONE_LVL <= cmcr_mono(PHONE_RST);
      end else begin
         O_LINE_LVL <= cmcr_stereo(master_q);
         O_HP_LVL <= cmcr_stereo(hp_q);
         O_MONO_LVL <= cmcr_mono(mono_q);
         O_PHONE_LVL <= cmcr_mono(phone_q);
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_BEEP_CTRL <= '{mute: 1'b1, beep_source_select: 1'b0, divisor: 8'h00, gain: 4'h0};
         O_BEEP_TONE <= 1'b0;
         O_BEEP_BYPASS <= 1'b1;
      end else begin
         O_BEEP_CTRL.mute <= beep_q[LMUTE_BIT];
         // Analog input passes once the host sets this bit, or via O_BEEP_BYPASS while the pin is low
         O_BEEP_CTRL.beep_source_select <= beep_q[BEEP_SRC_BIT];
         O_BEEP_CTRL.divisor <= beep_q[BEEP_DIV_LSB +: 8];
         O_BEEP_CTRL.gain <= beep_q[BEEP_GAIN_LSB +: 4];
         O_BEEP_TONE <= tone_q;
         // Unamplified straight path while the pin is low
         O_BEEP_BYPASS <= hw_rst;
      end
   end

   // Boost straps are pins: first flop here, output flop second
   logic [3:0] mic_meta_q;

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         mic_meta_q <= 4'h0;
         O_MIC_CTRL <= '{sum_to_mono: 1'b1, left_boost: 2'h0, right_boost: 2'h0};
         O_SERIAL_CFG <= '0;
      end else begin
         mic_meta_q <= {I_MIC_L_BOOST, I_MIC_R_BOOST};
         O_MIC_CTRL.sum_to_mono <= 1'b1;
         O_MIC_CTRL.left_boost <= mic_meta_q[3:2];
         O_MIC_CTRL.right_boost <= mic_meta_q[1:0];
         O_SERIAL_CFG.sixteen_bit_slot_mode <= serial_q[SLOT_MODE_BIT];
         O_SERIAL_CFG.register_map_select <= serial_q[REGMAP_LSB +: 3];
         O_SERIAL_CFG.digital_out_override <= serial_q[DOVR_BIT];
         O_SERIAL_CFG.digital_out_alignment <= serial_q[DALIGN_BIT];
         O_SERIAL_CFG.digital_out_zero_fill <= serial_q[DZERO_BIT];
         O_SERIAL_CFG.digital_out_link_mode <= serial_q[DLINK_BIT];
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);

   AST_SOFT_RESET_DEFAULTS: assert property (soft_rst |=>
      master_q == MASTER_RST && beep_q == BEEP_RST && phone_q == PHONE_RST)
      else $error("register reset did not restore defaults");

   AST_SERIAL_KEPT: assert property (soft_rst && !hit(SERIAL_IDX) |=>
      $stable(serial_q))
      else $error("serial config changed by register reset");

   AST_STICKY_KEPT: assert property (hw_rst |=>
      $stable(svid_q) && $stable(class_q) && $stable(sense_q))
      else $error("sticky page-one register changed in hardware reset");

   AST_ID_READ: assert property (I_REG_RD && I_REG_ADDR == RESET_IDX |=>
      O_REG_RVALID && O_REG_RDATA == {1'b0, STEREO_ENH_CODE, CAPABILITY})
      else $error("reset register read returned wrong word");

   AST_CAPABILITY: assert property (id_word[CAP_HP_BIT] && id_word[CAP_DAC20_BIT]
      && id_word[CAP_ADC20_BIT] && $countones(id_word) == 3)
      else $error("capability bits wrong");

   AST_LINE_FOLLOWS: assert property (hit(MASTER_IDX) && !soft_rst |=> ##1
      O_LINE_LVL == cmcr_stereo($past(I_REG_WDATA, 2) & STEREO_MASK))
      else $error("line level does not follow master write");

   AST_HP_IGNORES_MASTER: assert property (hit(MASTER_IDX) |=> ##1
      $stable(O_HP_LVL) && $stable(O_MONO_LVL))
      else $error("headphone or mono moved on master write");

   AST_MONO_MASKED: assert property (hit(MONO_IDX) |=>
      mono_q == ($past(I_REG_WDATA) & MONO_MASK))
      else $error("mono register reserved bits not ignored");

   AST_BEEP_MUTE_SILENT: assert property (beep_q[LMUTE_BIT] [*2] |=>
      !O_BEEP_TONE)
      else $error("muted beep still toggles");

   AST_DIV_ZERO_SILENT: assert property ((beep_q[BEEP_DIV_LSB +: 8] == 8'h00) [*2] |=>
      !O_BEEP_TONE)
      else $error("zero divisor still generates tone");

   AST_BYPASS_PIN: assert property (!hw_sync_q |=> O_BEEP_BYPASS ##1
      O_LINE_LVL.left_mute)
      else $error("beep bypass not active in pin reset");

   AST_PHONE_DEFAULT: assert property (hw_rst |=> ##1
      O_PHONE_LVL == cmcr_mono(PHONE_RST))
      else $error("phone level default wrong after reset");

   AST_MIC_MONO: assert property (O_MIC_CTRL.sum_to_mono)
      else $error("microphone sum to mono dropped");

   COV_SOFT_RESET: cover property (hit(MASTER_IDX) ##[1:20] soft_rst);
   COV_TONE_EDGE: cover property (gen_run ##1 $rose(O_BEEP_TONE));
   COV_PIN_RESET: cover property ($fell(hw_sync_q) ##[1:10] $rose(hw_sync_q));
   COV_PAGE_ONE_WRITE: cover property (page_one && hit(SVID_IDX));

endmodule : cmcr_top

// ---- sim/cmcr_host_model.sv ----
// Host controller model that drives the register strobes of the bank
module cmcr_host_model
   import cmcr_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Register strobes toward the bank
   output logic o_wr,
   output logic o_rd,
   output logic [6:0] o_addr,
   output logic [15:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 7'h7F;
      o_wdata = 16'h0000;
   end

   // Released lines show the inverse, so a stale value never looks valid
   task automatic release_bus();
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_addr <= ~o_addr;
      o_wdata <= ~o_wdata;
   endtask : release_bus

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      release_bus();
   endtask : wr

   task automatic rd(input logic [6:0] a);
      @(posedge i_clk);
      o_rd <= 1'b1;
      o_addr <= a;
      release_bus();
   endtask : rd

   // Analog beep passes once the host has picked the analog source, or through the bypass while the reset pin is low
   task automatic use_analog_beep(input logic [15:0] bv);
      wr(BEEP_IDX, bv | 16'h4000);
   endtask : use_analog_beep
endmodule : cmcr_host_model

// ---- sim/test_codec_mixer_control_registers.sv ----
// Self-checking bench for the mixer control register bank
module test_codec_mixer_control_registers
   import cmcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ext_n = 1'b1;
   logic [1:0] mic_l = 2'h0;
   logic [1:0] mic_r = 2'h0;
   logic wr, rd, rvalid;
   logic [6:0] addr;
   logic [15:0] wdata, rdata, exp_rd, sv;
   cmcr_stereo_s line_lvl, hp_lvl;
   cmcr_mono_s mono_lvl, phone_lvl;
   cmcr_beep_s beep_ctrl;
   logic tone, bypass;
   cmcr_mic_s mic_ctrl;
   cmcr_serial_s serial_cfg;
   logic [15:0] exp_q[$];
   int fail_count = 0;
   int comparisons = 0;
   int seed = 26;
   int cyc = 0;
   int n;
   // Reset register first; random writes skip it
   logic [6:0] ra[6] = '{RESET_IDX, MASTER_IDX, HP_IDX, MONO_IDX, BEEP_IDX, PHONE_IDX};
   // Capability: headphone, 20-bit DAC, 20-bit ADC
   logic [15:0] rdef[6] = '{16'h0200 | 16'h0080 | 16'h0010, 16'h8080, 16'h8080, 16'h8000,
                            16'h8000, 16'h8008};
   logic [15:0] rmask[6] = '{16'h0000, 16'h9F9F, 16'h9F9F, 16'h801F, 16'hDFFE, 16'h801F};
   logic [15:0] wd[6];
   logic [15:0] bv[3] = '{16'h0000, 16'h8020, 16'h4020};

   always #10 clk = ~clk;

   cmcr_host_model host (
      .i_clk(clk),
      .o_wr(wr),
      .o_rd(rd),
      .o_addr(addr),
      .o_wdata(wdata)
   );

   cmcr_top dut (
      .I_CORE_CLK(clk),
      .I_RST_N(rst_n),
      .I_EXT_RESET_N(ext_n),
      .I_REG_WR(wr),
      .I_REG_RD(rd),
      .I_REG_ADDR(addr),
      .I_REG_WDATA(wdata),
      .O_REG_RDATA(rdata),
      .O_REG_RVALID(rvalid),
      .I_MIC_L_BOOST(mic_l),
      .I_MIC_R_BOOST(mic_r),
      .O_LINE_LVL(line_lvl),
      .O_HP_LVL(hp_lvl),
      .O_MONO_LVL(mono_lvl),
      .O_PHONE_LVL(phone_lvl),
      .O_BEEP_CTRL(beep_ctrl),
      .O_BEEP_TONE(tone),
      .O_BEEP_BYPASS(bypass),
      .O_MIC_CTRL(mic_ctrl),
      .O_SERIAL_CFG(serial_cfg)
   );

   function automatic logic [15:0] st(input logic [15:0] d);
      return {4'h0, d[15], d[12:8], d[7], d[4:0]};
   endfunction : st

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask : rd_chk

   task automatic settle();
      repeat (4) @(negedge clk);
   endtask : settle

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   // Read answers come one cycle after the strobe and pair with the oldest note
   always @(negedge clk) begin
      if (rvalid === 1'b1) begin
         exp_rd = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hDEAD;
         chk(rdata, exp_rd, "read data");
      end
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         $display("unexpected at %0t: run did not finish", $time);
         wrap_up();
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      for (int i = 0; i < 6; i++) rd_chk(ra[i], rdef[i]);
      rd_chk(7'h3E, 16'h0000);
      settle();
      chk(line_lvl, 16'h0820, "line default");
      chk(phone_lvl, 16'h0028, "phone default");
      chk(beep_ctrl, 16'h2000, "beep default");
      $display("test defaults done");

      for (int i = 1; i < 6; i++) begin
         wd[i] = 16'($random(seed));
         host.wr(ra[i], wd[i]);
      end
      for (int i = 1; i < 6; i++) rd_chk(ra[i], wd[i] & rmask[i]);
      settle();
      chk(line_lvl, st(wd[1]), "line level");
      chk(hp_lvl, st(wd[2]), "headphone level");
      chk(mono_lvl, {wd[3][15], wd[3][4:0]}, "mono level");
      chk(beep_ctrl, {wd[4][15:14], wd[4][12:1]}, "beep control");
      chk(phone_lvl, {wd[5][15], wd[5][4:0]}, "phone level");
      $display("test random writes done");

      sv = 16'($random(seed));
      host.wr(SERIAL_IDX, 16'hA028);
      host.wr(PAGE_IDX, 16'h0001);
      host.wr(CLASS_IDX, sv);
      host.wr(SENSE_IDX, 16'hFFFF);
      rd_chk(SENSE_IDX, 16'hE000);
      host.wr(RESET_IDX, 16'($random(seed)));
      for (int i = 0; i < 6; i++) rd_chk(ra[i], rdef[i]);
      rd_chk(SERIAL_IDX, 16'hA028);
      host.wr(PAGE_IDX, 16'h0001);
      rd_chk(CLASS_IDX, sv);
      settle();
      chk(serial_cfg, 16'h00AA, "serial kept");
      chk(line_lvl, 16'h0820, "line after reset");
      $display("test register reset done");

      @(posedge clk);
      ext_n <= 1'b0;
      settle();
      chk(bypass, 1'b1, "bypass in pin reset");
      host.wr(MASTER_IDX, 16'h0000);
      settle();
      chk(serial_cfg, 16'h0000, "serial cleared");
      chk(line_lvl, 16'h0820, "pin reset write refused");
      @(posedge clk);
      ext_n <= 1'b1;
      settle();
      chk(bypass, 1'b0, "bypass released");
      host.wr(PAGE_IDX, 16'h0001);
      rd_chk(CLASS_IDX, sv);
      rd_chk(SENSE_IDX, 16'hE000);
      $display("test pin reset done");

      host.wr(BEEP_IDX, 16'h0020);
      n = 0;
      while (tone !== 1'b1 && n < 6000) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (tone === 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      chk(16'(n), 16'(2 * 1041), "tone half period");
      // Each setting must keep the tone silent for longer than a half period
      for (int k = 0; k < 3; k++) begin
         if (bv[k][14]) host.use_analog_beep(bv[k]);
         else host.wr(BEEP_IDX, bv[k]);
         settle();
         n = 0;
         repeat (2500) begin
            @(negedge clk);
            n += (tone !== 1'b0);
         end
         chk(16'(n), 16'h0000, "tone silent");
      end
      $display("test beep done");

      repeat (4) begin
         @(posedge clk);
         mic_l <= 2'($random(seed));
         mic_r <= 2'($random(seed));
         repeat (3) @(negedge clk);
         chk(mic_ctrl, {11'h000, 1'b1, mic_l, mic_r}, "mic control");
      end
      $display("test mic done");

      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      host.wr(PAGE_IDX, 16'h0001);
      rd_chk(CLASS_IDX, 16'h0000);
      rd_chk(SERIAL_IDX, 16'h0000);
      settle();
      chk(16'(exp_q.size()), 16'h0000, "pending reads");
      $display("test power-on reset done");
      wrap_up();
   end
endmodule : test_codec_mixer_control_registers
